// ===== hw/acc_map.vh
// Register map, field positions, reset values and timing counts for the
// converter control block. Assumes a 40 MHz pclk and 32-bit APB words.
`ifndef ACC_MAP_VH
`define ACC_MAP_VH
`define ACC_CTRL_OFF      12'h0c0
`define ACC_PDIS_OFF      12'h0c4
`define ACC_RESULT_OFF    12'h0c8
`define ACC_PIN_OFF       12'h0cc
`define ACC_CFG_OFF       12'h0d0
`define ACC_CTRL_RST      8'h00
`define ACC_PDIS_RST      8'h00
`define ACC_B_ENABLE      7
`define ACC_B_OUT1        6
`define ACC_B_OUT0        5
`define ACC_B_DONE        4
`define ACC_B_START       3
`define ACC_B_RCSEL       2
`define ACC_B_CHHI        1
`define ACC_B_CHLO        0
`define ACC_CFG_GIE       0
`define ACC_CFG_IEN       1
`define ACC_CFG_PRIO      2
`define ACC_CFG_PDOWN     3
`define ACC_MC_CLKS       6
`define ACC_CONV_MC       31
`define ACC_SYNC_MC       3
`define ACC_RC_CLKS       108
`define ACC_RC_DIV        7
`define ACC_PIN_CH0       3
`define ACC_PIN_CH1       4
`define ACC_PIN_CH2       5
`define ACC_PIN_CH3       6
`endif

// ===== hw/acc_top.v
// Converter control: control register, digital input disable, start/busy/
// done sequencing, result holding and interrupt request over APB.
// Assumes pin levels and the sample value are synchronous to pclk.
//
// Added by the designer: register access over APB.
`include "acc_map.vh"

////////////////////////////////////////////////////////////////////////////
// Functional notes
// - Each input-disable bit turns off one port 0 pin's digital input.
// - A disabled port 0 pin reads as zero.
// - Four-way input selector feeding an 8-bit successive approximation core.
// - Channel bits change only while busy and done are both zero.
// - Start begins conversion; start reads one until one machine cycle after completion.
// - Hardware sets done on completion; only software clears it.
// - Start is ignored while busy or done is one.
// - Done and busy are both set for exactly one machine cycle, except after a power-down abort on the finish tick.
// - Start write may change channel; a done-clearing write may not.
// - Interrupt needs global enable, converter interrupt enable and top priority.
// - Result loads at completion and holds until the next completion or a power-down abort.
// - Enable cannot be cleared while busy or done is one.
// - Clock select: 0 CPU clock, 1 RC; writable only when idle.
// - Bit 6 enables the second output converter.
// - Bit 5 enables first output converter; writable only when idle.
// - Code 00 selects pin 3, code 01 selects pin 4.
// - Control register at C0h, resets to zero, fixed bit layout.
// - CPU-clocked conversion finishes 31 machine cycles after start.
// - RC-clocked conversion adds 3 machine cycles sync plus 108 RC clocks.
// - Power-down with CPU clock aborts conversion, result invalid.
module acc_top (
  input  wire        pclk,
  input  wire        presetn,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [11:0] paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output reg         pready,
  output reg         pslverr,
  input  wire [7:0]  port0_pin_in,
  output reg  [7:0]  port0_digital_input_disable,
  output reg  [7:0]  port0_read_value,
  input  wire [7:0]  sar_sample,
  output reg  [1:0]  analog_mux_sel,
  output reg  [7:0]  analog_mux_pin_onehot,
  output reg         converter_enable,
  output reg         second_output_converter_enable,
  output reg         first_output_converter_enable,
  output reg         rc_oscillator_clock_select,
  output reg         conversion_busy,
  output reg         irq_request
);

  // Sequencer states
  localparam [1:0] ST_IDLE = 2'b00;
  localparam [1:0] ST_SYNC = 2'b01;
  localparam [1:0] ST_CONV = 2'b10;
  localparam [1:0] ST_DONE = 2'b11;

  ////////////////////////////////////////////////////////////////////////////
  // Timing overview
  //
  // Machine cycle:
  //   The machine cycle divider runs freely from reset and never resyncs.
  //   A start therefore lands at any phase of it.
  //   The first machine cycle of a conversion is a partial one.
  //   Counts below are ticks after that partial cycle, except the CPU clock total, which includes it.
  //
  // CPU clock conversion:
  //   The count loads with the machine cycle total less one.
  //   Done sets on the tick after the count reaches zero.
  //   Start to done is the full total, the partial cycle included.
  //
  // RC clock conversion:
  //   A sync phase of whole machine cycles comes first.
  //   The RC phase then counts RC ticks from the /7 divider.
  //   Both phases end on a tick, so the sum has a small spread.
  //   Anything checking the length must allow for that spread.
  //
  // Done overlap:
  //   Done and busy stand together for one machine cycle.
  //   That cycle is counted in pclk, so it is exact in both clock modes.
  //   An RC tick lines up with the machine cycle divider only once every 42 pclk.
  //   Waiting for the next machine tick would shorten the overlap.
  //
  // Clock select at start:
  //   A start write may also change the clock select bit.
  //   The sequencer takes the written value, not the old register bit.
  //   Otherwise the sync phase and the finish test could disagree.
  //
  // Lock rules:
  //   Locked fields are compared against the state before the write.
  //   A write that clears done still sees the block as locked.
  //   A start in the same write as a done clear is therefore ignored.
  //
  // Power-down:
  //   Only CPU clocked conversions abort on a power-down request.
  //   An abort leaves done clear and the result invalid, except on the finish tick, where finish sets both.
  //   An abort cannot cut the done overlap cycle short, but an abort on the finish tick clears busy as done sets, so there is no overlap.
  //
  // Counter widths:
  //   Load values are cut to the counter width on purpose.
  //   Every load value here fits its counter without loss.
  //
  ////////////////////////////////////////////////////////////////////////////

  // Divider end points and sequencer load values
  localparam integer MC_LAST_I   = `ACC_MC_CLKS - 1;
  localparam integer RC_LAST_I   = `ACC_RC_DIV - 1;
  localparam integer CONV_LD_I   = `ACC_CONV_MC - 1;
  localparam integer SYNC_LD_I   = `ACC_SYNC_MC;
  localparam integer RCCONV_LD_I = `ACC_RC_CLKS;
  localparam [2:0]   MC_LAST     = MC_LAST_I[2:0];
  localparam [2:0]   RC_LAST     = RC_LAST_I[2:0];
  localparam [6:0]   CONV_LD     = CONV_LD_I[6:0];
  localparam [6:0]   SYNC_LD     = SYNC_LD_I[6:0];
  localparam [6:0]   RCCONV_LD   = RCCONV_LD_I[6:0];
  localparam [6:0]   DONE_LD     = MC_LAST_I[6:0];

  // Selector decode, used for the pin one-hot output
  function [7:0] ch_pin;
    input [1:0] ch;
    begin
      case (ch)
        2'b00:   ch_pin = 8'h01 << `ACC_PIN_CH0;
        2'b01:   ch_pin = 8'h01 << `ACC_PIN_CH1;
        2'b10:   ch_pin = 8'h01 << `ACC_PIN_CH2;
        2'b11:   ch_pin = 8'h01 << `ACC_PIN_CH3;
        default: ch_pin = 8'h00;
      endcase
    end
  endfunction

  reg [7:0]  ctrl_q;
  reg [7:0]  pdis_q;
  reg [7:0]  result_q;
  reg [3:0]  cfg_q;
  reg [1:0]  state_q;
  reg [2:0]  mc_cnt_q;
  reg [6:0]  cyc_cnt_q;
  reg [2:0]  rc_div_q;
  reg        result_valid_q;

  wire       wr_en   = psel & penable & pwrite;
  wire       wr_ctrl = wr_en & (paddr == `ACC_CTRL_OFF);
  wire       wr_pdis = wr_en & (paddr == `ACC_PDIS_OFF);
  wire       wr_cfg  = wr_en & (paddr == `ACC_CFG_OFF);
  wire       busy    = ctrl_q[`ACC_B_START];
  wire       done    = ctrl_q[`ACC_B_DONE];
  wire       locked  = busy | done;
  wire       mc_tick = (mc_cnt_q == MC_LAST);
  wire       rc_tick = (rc_div_q == RC_LAST);
  // Last pclk of the one machine cycle done overlap
  wire       done_end = (state_q == ST_DONE) & (cyc_cnt_q == 7'd0);
  wire       start_ok = wr_ctrl & pwdata[`ACC_B_START] & ~locked
                        & ctrl_q[`ACC_B_ENABLE];
  wire       pdown_abort = cfg_q[`ACC_CFG_PDOWN] & ~ctrl_q[`ACC_B_RCSEL]
                           & (state_q != ST_IDLE) & (state_q != ST_DONE);
  wire       finish;

  assign finish = (state_q == ST_CONV) & (ctrl_q[`ACC_B_RCSEL] ? rc_tick : mc_tick)
                  & (cyc_cnt_q == 7'd0);

  ////////////////////////////////////////////////////////////////////////////
  // Machine cycle and RC clock dividers
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      mc_cnt_q <= 3'd0;
      rc_div_q <= 3'd0;
    end
    else
    begin
      mc_cnt_q <= mc_tick ? 3'd0 : mc_cnt_q + 3'd1;
      rc_div_q <= rc_tick ? 3'd0 : rc_div_q + 3'd1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Control register with locked fields
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      ctrl_q <= `ACC_CTRL_RST;
    else
    begin
      if (wr_ctrl)
      begin
        // Enable may always be set, cleared only when idle
        if (pwdata[`ACC_B_ENABLE] | ~locked)
          ctrl_q[`ACC_B_ENABLE] <= pwdata[`ACC_B_ENABLE];
        ctrl_q[`ACC_B_OUT1] <= pwdata[`ACC_B_OUT1];
        if (~locked)
        begin
          ctrl_q[`ACC_B_OUT0]  <= pwdata[`ACC_B_OUT0];
          ctrl_q[`ACC_B_RCSEL] <= pwdata[`ACC_B_RCSEL];
          ctrl_q[1:0]          <= pwdata[1:0];
        end
      end
      // Done flag: hardware set wins over software clear
      if (finish)
        ctrl_q[`ACC_B_DONE] <= 1'b1;
      else if (wr_ctrl & ~pwdata[`ACC_B_DONE])
        ctrl_q[`ACC_B_DONE] <= 1'b0;
      // Busy bit: set by accepted start, cleared one machine cycle after done or on abort
      if (start_ok)
        ctrl_q[`ACC_B_START] <= 1'b1;
      else if (done_end | pdown_abort)
        ctrl_q[`ACC_B_START] <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Conversion sequencer
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state_q   <= ST_IDLE;
      cyc_cnt_q <= 7'd0;
    end
    else if (pdown_abort)
    begin
      state_q   <= ST_IDLE;
      cyc_cnt_q <= 7'd0;
    end
    else
    begin
      case (state_q)
        ST_IDLE:
          if (start_ok)
          begin
            // Written clock select applies to this conversion
            if (pwdata[`ACC_B_RCSEL])
            begin
              state_q   <= ST_SYNC;
              cyc_cnt_q <= SYNC_LD;
            end
            else
            begin
              state_q   <= ST_CONV;
              cyc_cnt_q <= CONV_LD;
            end
          end
        ST_SYNC:
          if (mc_tick)
          begin
            if (cyc_cnt_q == 7'd0)
            begin
              state_q   <= ST_CONV;
              cyc_cnt_q <= RCCONV_LD;
            end
            else
              cyc_cnt_q <= cyc_cnt_q - 7'd1;
          end
        ST_CONV:
          if (finish)
          begin
            state_q   <= ST_DONE;
            cyc_cnt_q <= DONE_LD;
          end
          else if (ctrl_q[`ACC_B_RCSEL] ? rc_tick : mc_tick)
            cyc_cnt_q <= cyc_cnt_q - 7'd1;
        ST_DONE:
          if (cyc_cnt_q == 7'd0)
            state_q <= ST_IDLE;
          else
            cyc_cnt_q <= cyc_cnt_q - 7'd1;
        default:
          state_q <= ST_IDLE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Result, input disable and interrupt configuration registers
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      result_q       <= 8'h00;
      result_valid_q <= 1'b0;
      pdis_q         <= `ACC_PDIS_RST;
      cfg_q          <= 4'h0;
    end
    else
    begin
      if (finish)
      begin
        result_q       <= sar_sample;
        result_valid_q <= 1'b1;
      end
      else if (pdown_abort)
      begin
        result_q       <= 8'h00;
        result_valid_q <= 1'b0;
      end
      if (wr_pdis)
        pdis_q <= pwdata[7:0];
      if (wr_cfg)
        cfg_q <= pwdata[3:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // APB slave: zero wait states, error on unmapped address
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prdata  <= 32'h0000_0000;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end
    else
    begin
      pready  <= psel & ~penable;
      pslverr <= 1'b0;
      if (psel & ~penable)
      begin
        case (paddr)
          `ACC_CTRL_OFF:   prdata <= {24'h000000, ctrl_q};
          `ACC_PDIS_OFF:   prdata <= {24'h000000, pdis_q};
          `ACC_RESULT_OFF: prdata <= {23'h000000, result_valid_q, result_q};
          `ACC_PIN_OFF:    prdata <= {24'h000000, port0_pin_in & ~pdis_q};
          `ACC_CFG_OFF:    prdata <= {28'h0000000, cfg_q};
          default:
          begin
            prdata  <= 32'h0000_0000;
            pslverr <= 1'b1;
          end
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Registered outputs toward pins, analog core and interrupt logic
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      port0_digital_input_disable    <= 8'h00;
      port0_read_value               <= 8'h00;
      analog_mux_sel                 <= 2'b00;
      analog_mux_pin_onehot          <= 8'h00;
      converter_enable               <= 1'b0;
      second_output_converter_enable <= 1'b0;
      first_output_converter_enable  <= 1'b0;
      rc_oscillator_clock_select     <= 1'b0;
      conversion_busy                <= 1'b0;
      irq_request                    <= 1'b0;
    end
    else
    begin
      port0_digital_input_disable    <= pdis_q;
      port0_read_value               <= port0_pin_in & ~pdis_q;
      analog_mux_sel                 <= ctrl_q[1:0];
      analog_mux_pin_onehot          <= ch_pin(ctrl_q[1:0]);
      converter_enable               <= ctrl_q[`ACC_B_ENABLE];
      second_output_converter_enable <= ctrl_q[`ACC_B_OUT1];
      first_output_converter_enable  <= ctrl_q[`ACC_B_OUT0];
      rc_oscillator_clock_select     <= ctrl_q[`ACC_B_RCSEL];
      conversion_busy                <= busy;
      irq_request                    <= done & cfg_q[`ACC_CFG_GIE]
                                        & cfg_q[`ACC_CFG_IEN] & cfg_q[`ACC_CFG_PRIO];
    end
  end

endmodule // acc_top

// ===== bench/acc_pins.sv
// Far-side model: port 0 pin levels and the analog core sample.
// Assumes the bench sets pin levels and a drift term.
module acc_pins (
  input  wire logic [1:0] analog_mux_sel,
  input  wire logic [7:0] pin_level,
  input  wire logic [7:0] drift,
  output logic      [7:0] port0_pin_in,
  output logic      [7:0] sar_sample
);
  // Raw pins, digital buffer masking happens in the block
  assign port0_pin_in = pin_level;
  // One distinct code per selected input, four inputs
  assign sar_sample = (8'h3c + 8'h21 * analog_mux_sel) ^ drift;
endmodule // acc_pins

// ===== bench/acc_top_sva.sv
// Checker on the converter control ports.
// Assumes one pclk domain and a bind to every acc_top.
module acc_top_sva (
  input wire logic       pclk,
  input wire logic       presetn,
  input wire logic       psel,
  input wire logic       penable,
  input wire logic       pready,
  input wire logic [7:0] port0_digital_input_disable,
  input wire logic [7:0] port0_read_value,
  input wire logic [1:0] analog_mux_sel,
  input wire logic [7:0] analog_mux_pin_onehot,
  input wire logic       converter_enable,
  input wire logic       first_output_converter_enable,
  input wire logic       rc_oscillator_clock_select,
  input wire logic       conversion_busy,
  input wire logic       irq_request
);
  localparam int CMIN = 186;
  localparam int CMAX = 198;
  localparam int RMIN = 770;
  localparam int RMAX = 800;
  logic [9:0] busy_cnt_q;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // Length of the current busy run
  always @(posedge pclk or negedge presetn)
    if (!presetn) busy_cnt_q <= 10'h000;
    else busy_cnt_q <= conversion_busy ? busy_cnt_q + 10'h001 : 10'h000;
  a_read_masked: assert property (
    (port0_read_value & port0_digital_input_disable) == 8'h00) else $error("masked pin read");
  a_mux_onehot: assert property (
    conversion_busy |-> analog_mux_pin_onehot == (8'h08 << analog_mux_sel))
    else $error("bad pin select");
  a_chan_lock: assert property (
    conversion_busy && $past(conversion_busy) |-> $stable(analog_mux_sel))
    else $error("channel moved while busy");
  a_clk_lock: assert property (
    conversion_busy && $past(conversion_busy) |-> $stable(rc_oscillator_clock_select))
    else $error("clock select moved while busy");
  a_out0_lock: assert property (
    conversion_busy && $past(conversion_busy) |-> $stable(first_output_converter_enable))
    else $error("first output moved while busy");
  a_enable_held: assert property (
    conversion_busy |-> converter_enable) else $error("enable low while busy");
  a_cpu_time: assert property (
    $fell(conversion_busy) && !rc_oscillator_clock_select |-> busy_cnt_q >= CMIN
    && busy_cnt_q <= CMAX) else $error("cpu clock conversion length");
  a_rc_time: assert property (
    $fell(conversion_busy) && rc_oscillator_clock_select |-> busy_cnt_q >= RMIN
    && busy_cnt_q <= RMAX) else $error("rc clock conversion length");
  a_done_overlap: assert property (
    $rose(irq_request) |-> conversion_busy [*6] ##1 !conversion_busy)
    else $error("done and busy overlap length");
  a_zero_wait: assert property (
    psel && penable |-> pready) else $error("access without ready");
endmodule // acc_top_sva

bind acc_top acc_top_sva u_sva (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pready(pready),
  .port0_digital_input_disable(port0_digital_input_disable),
  .port0_read_value(port0_read_value), .analog_mux_sel(analog_mux_sel),
  .analog_mux_pin_onehot(analog_mux_pin_onehot), .converter_enable(converter_enable),
  .first_output_converter_enable(first_output_converter_enable),
  .rc_oscillator_clock_select(rc_oscillator_clock_select),
  .conversion_busy(conversion_busy), .irq_request(irq_request));

// ===== bench/acc_top_tb.sv
// Register-level bench for the converter control block over APB.
// Assumes zero wait state slave and the pin model beside it.
`include "acc_map.vh"
module acc_top_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic        pclk = 1'b0;
  logic        presetn = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [7:0]  pin_level = 8'hff;
  logic [7:0]  drift = 8'h00;
  logic [31:0] rd;
  logic        err;
  logic [7:0]  exp;
  int          error_cnt = 0;
  int          num_checks = 0;
  wire  [31:0] prdata;
  wire  [7:0]  pin_in, sample, pdis, onehot;
  wire  [1:0]  msel;
  wire         pready, pslverr, out1, irq;
  always #12.5 pclk = ~pclk;
  acc_pins u_pins (.analog_mux_sel(msel), .pin_level(pin_level), .drift(drift),
    .port0_pin_in(pin_in), .sar_sample(sample));
  acc_top dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .port0_pin_in(pin_in), .port0_digital_input_disable(pdis),
    .port0_read_value(), .sar_sample(sample), .analog_mux_sel(msel),
    .analog_mux_pin_onehot(onehot), .converter_enable(), .second_output_converter_enable(out1),
    .first_output_converter_enable(), .rc_oscillator_clock_select(),
    .conversion_busy(), .irq_request(irq));
  ////////////////////////////////////////////////////////////////////////
  // Verdict and exit
  task complete_run(input bit hung);
    if (hung) error_cnt++;
    if (error_cnt == 0 && num_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  // Value compare
  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    num_checks++;
    if (g !== e)
    begin
      error_cnt++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask
  // One APB transfer, held until pready at an edge
  task apb(input logic [11:0] a, input logic w, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1; penable <= 1'b0; paddr <= a; pwrite <= w; pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1)
    begin
      n++;
      if (n > 16) complete_run(1'b1);
      @(posedge pclk);
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task rdc(input logic [11:0] a, input logic [31:0] e, input string nm);
    apb(a, 1'b0, 32'h0);
    chk(nm, e, rd);
  endtask
  // Poll the done flag, then let the overlap cycle pass
  task wait_done(input int lim);
    int n;
    n = 0;
    apb(`ACC_CTRL_OFF, 1'b0, 32'h0);
    while (rd[4] !== 1'b1)
    begin
      n++;
      if (n > lim) complete_run(1'b1);
      apb(`ACC_CTRL_OFF, 1'b0, 32'h0);
    end
    repeat (8) @(posedge pclk);
  endtask
  ////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial
  begin
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    rdc(`ACC_CTRL_OFF, 32'h0, "ctrl reset");
    rdc(12'h0f0, 32'h0, "unmapped");
    chk("slverr", 32'h1, {31'h0, err});
    apb(`ACC_PDIS_OFF, 1'b1, 32'h78);
    rdc(`ACC_PIN_OFF, 32'h87, "pin read");
    chk("disable out", 32'h78, {24'h0, pdis});
    apb(`ACC_CFG_OFF, 1'b1, 32'h7);
    apb(`ACC_CTRL_OFF, 1'b1, 32'h80);
    repeat (400) @(posedge pclk);
    for (int c = 0; c < 4; c++)
    begin
      exp = (8'h3c + 8'h21 * c[7:0]) ^ drift;
      apb(`ACC_CTRL_OFF, 1'b1, 32'h88 | c);
      rdc(`ACC_CTRL_OFF, 32'h88 | c, "busy");
      chk("mux sel", c, {30'h0, msel});
      apb(`ACC_CTRL_OFF, 1'b1, 32'h2c | (c ^ 1));
      rdc(`ACC_CTRL_OFF, 32'h88 | c, "locked");
      wait_done(100);
      rdc(`ACC_CTRL_OFF, 32'h90 | c, "done");
      chk("irq set", 32'h1, {31'h0, irq});
      rdc(`ACC_RESULT_OFF, 32'h100 | exp, "result");
      drift <= drift + 8'h5b;
      apb(`ACC_CTRL_OFF, 1'b1, 32'h98 | c);
      rdc(`ACC_RESULT_OFF, 32'h100 | exp, "held");
      rdc(`ACC_CTRL_OFF, 32'h90 | c, "restart");
      apb(`ACC_CTRL_OFF, 1'b1, 32'h80 | (c ^ 2));
      rdc(`ACC_CTRL_OFF, 32'h80 | c, "cleared");
      chk("irq clear", 32'h0, {31'h0, irq});
    end
    apb(`ACC_CTRL_OFF, 1'b1, 32'h84);
    rdc(`ACC_CTRL_OFF, 32'h84, "rc select");
    exp = 8'h3c ^ drift;
    apb(`ACC_CTRL_OFF, 1'b1, 32'h8c);
    wait_done(400);
    rdc(`ACC_RESULT_OFF, 32'h100 | exp, "rc result");
    apb(`ACC_CTRL_OFF, 1'b1, 32'h00);
    rdc(`ACC_CTRL_OFF, 32'h84, "enable kept");
    apb(`ACC_CTRL_OFF, 1'b1, 32'h00);
    apb(`ACC_CTRL_OFF, 1'b1, 32'h08);
    rdc(`ACC_CTRL_OFF, 32'h0, "start off");
    apb(`ACC_CTRL_OFF, 1'b1, 32'h40);
    repeat (2) @(posedge pclk);
    chk("second out", 32'h1, {31'h0, out1});
    complete_run(1'b0);
  end
endmodule // acc_top_tb
